//--- hdl/stls_pkg.sv
// Purpose: shared constants and types of the serdes transmit level selector
// Assumes: byte addressed plain register port, 32-bit words, word aligned
// Notes:   field positions and reset values of the lane transmit control pair
package stls_pkg;

  typedef enum logic [2:0] {
    STLS_FS35_R1,
    STLS_FS35_R2,
    STLS_FS60_R2,
    STLS_LS_R1,
    STLS_LS_R2
  } stls_mode_t;

  localparam int BUS_AW = 10;
  localparam int BUS_DW = 32;

  // address map
  localparam logic [9:0] QUAD_BASE      = 10'h000;
  localparam int         QUAD_STRIDE_SH = 4;
  localparam logic [3:0] OFS_TXL_FIRST  = 4'h0;
  localparam logic [3:0] OFS_TXL_SECOND = 4'h4;
  localparam logic [3:0] OFS_TARGET     = 4'h8;
  localparam logic [9:0] PORT_BASE      = 10'h200;

  // field widths
  localparam int SLEW_W  = 3;
  localparam int TXEQ_W  = 2;
  localparam int CDC_W   = 3;
  localparam int FDC_W   = 3;
  localparam int DRV_W   = 5;
  localparam int DRVLS_W = 4;
  localparam int MARGIN_W = 3;
  localparam int LSEL_W  = 2;

  // first register of the pair
  localparam int POS_CSLEW_R1   = 0;
  localparam int POS_CSLEW_R2   = 3;
  localparam int POS_TXEQ_35R1  = 6;
  localparam int POS_TXEQ_35R2  = 8;
  localparam int POS_TXEQ_60R2  = 10;
  localparam int POS_FSLEW_R1   = 12;
  localparam int POS_FSLEW_R2   = 15;
  localparam int POS_CDC_35R1   = 18;
  localparam int POS_CDC_35R2   = 21;
  localparam int POS_CDC_60R2   = 24;
  localparam logic [31:0] TXL_FIRST_MASK = 32'h07ff_ffff;
  localparam logic [31:0] TXL_FIRST_RST  =
    {5'h00, 3'h1, 3'h1, 3'h3, 3'h0, 3'h0, 2'h1, 2'h1, 2'h2, 3'h0, 3'h2};

  // second register of the pair
  localparam int POS_FDC_35R1   = 0;
  localparam int POS_FDC_35R2   = 3;
  localparam int POS_FDC_60R2   = 6;
  localparam int POS_DRV_35R1   = 9;
  localparam int POS_DRV_35R2   = 14;
  localparam int POS_DRV_60R2   = 19;
  localparam int POS_DRV_LSR1   = 24;
  localparam int POS_DRV_LSR2   = 28;
  localparam logic [31:0] TXL_SECOND_MASK = 32'hffff_ffff;
  localparam logic [31:0] TXL_SECOND_RST  =
    {4'h8, 4'h8, 5'h14, 5'h18, 5'h18, 3'h3, 3'h4, 3'h4};

  // quad lane target control
  localparam int              POS_LANE_SEL  = 0;
  localparam int              POS_ALL_LANES = 4;
  localparam logic [LSEL_W-1:0] LANE_SEL_RST = 2'h0;
  localparam logic            ALL_LANES_RST = 1'b0;

  // port link control two
  localparam int                  POS_MARGIN    = 0;
  localparam int                  POS_MODE_STAT = 4;
  localparam int                  POS_MERGED    = 8;
  localparam logic [MARGIN_W-1:0] MARGIN_NORMAL = 3'h0;
  localparam logic [MARGIN_W-1:0] MARGIN_RST    = 3'h0;

endpackage : stls_pkg

//--- hdl/stls_lane_drv.sv
// Purpose: per-lane pick of transmit driver fields for the current mode
// Assumes: mode and margin come from logic on the same clock
// Notes:   outputs are registered, settle one cycle after any change
`timescale 1ns/100ps
module stls_lane_drv (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [31:0]                   first_i,
  input  wire logic [31:0]                   second_i,
  input  wire stls_pkg::stls_mode_t          mode_i,
  input  wire logic [stls_pkg::MARGIN_W-1:0] margin_i,
  output logic      [stls_pkg::DRV_W-1:0]    drv_level_o,
  output logic      [stls_pkg::CDC_W-1:0]    deemph_coarse_o,
  output logic      [stls_pkg::FDC_W-1:0]    deemph_fine_o,
  output logic      [stls_pkg::TXEQ_W-1:0]   tx_equal_o,
  output logic      [stls_pkg::SLEW_W-1:0]   slew_coarse_o,
  output logic      [stls_pkg::SLEW_W-1:0]   slew_fine_o,
  output logic                               margin_drive_o,
  output logic      [stls_pkg::MARGIN_W-1:0] margin_value_o
);

  logic [stls_pkg::DRV_W-1:0]  drv_nxt;
  logic [stls_pkg::CDC_W-1:0]  cdc_nxt;
  logic [stls_pkg::FDC_W-1:0]  fdc_nxt;
  logic [stls_pkg::TXEQ_W-1:0] txeq_nxt;
  logic [stls_pkg::SLEW_W-1:0] cslew_nxt;
  logic [stls_pkg::SLEW_W-1:0] fslew_nxt;
  logic                        direct;

  assign direct = (margin_i != stls_pkg::MARGIN_NORMAL);

  always_comb begin
    drv_nxt   = '0;
    cdc_nxt   = '0;
    fdc_nxt   = '0;
    txeq_nxt  = '0;
    cslew_nxt = first_i[stls_pkg::POS_CSLEW_R1 +: stls_pkg::SLEW_W];
    fslew_nxt = first_i[stls_pkg::POS_FSLEW_R1 +: stls_pkg::SLEW_W];
    unique case (mode_i)
      stls_pkg::STLS_FS35_R1: begin
        cdc_nxt  = first_i[stls_pkg::POS_CDC_35R1 +: stls_pkg::CDC_W];
        txeq_nxt = first_i[stls_pkg::POS_TXEQ_35R1 +: stls_pkg::TXEQ_W];
        drv_nxt  = second_i[stls_pkg::POS_DRV_35R1 +: stls_pkg::DRV_W];
        fdc_nxt  = second_i[stls_pkg::POS_FDC_35R1 +: stls_pkg::FDC_W];
      end
      stls_pkg::STLS_FS35_R2: begin
        cdc_nxt   = first_i[stls_pkg::POS_CDC_35R2 +: stls_pkg::CDC_W];
        txeq_nxt  = first_i[stls_pkg::POS_TXEQ_35R2 +: stls_pkg::TXEQ_W];
        drv_nxt   = second_i[stls_pkg::POS_DRV_35R2 +: stls_pkg::DRV_W];
        fdc_nxt   = second_i[stls_pkg::POS_FDC_35R2 +: stls_pkg::FDC_W];
        cslew_nxt = first_i[stls_pkg::POS_CSLEW_R2 +: stls_pkg::SLEW_W];
        fslew_nxt = first_i[stls_pkg::POS_FSLEW_R2 +: stls_pkg::SLEW_W];
      end
      stls_pkg::STLS_FS60_R2: begin
        cdc_nxt   = first_i[stls_pkg::POS_CDC_60R2 +: stls_pkg::CDC_W];
        txeq_nxt  = first_i[stls_pkg::POS_TXEQ_60R2 +: stls_pkg::TXEQ_W];
        drv_nxt   = second_i[stls_pkg::POS_DRV_60R2 +: stls_pkg::DRV_W];
        fdc_nxt   = second_i[stls_pkg::POS_FDC_60R2 +: stls_pkg::FDC_W];
        cslew_nxt = first_i[stls_pkg::POS_CSLEW_R2 +: stls_pkg::SLEW_W];
        fslew_nxt = first_i[stls_pkg::POS_FSLEW_R2 +: stls_pkg::SLEW_W];
      end
      stls_pkg::STLS_LS_R1: begin
        drv_nxt = {1'b0, second_i[stls_pkg::POS_DRV_LSR1 +: stls_pkg::DRVLS_W]};
      end
      stls_pkg::STLS_LS_R2: begin
        drv_nxt   = {1'b0, second_i[stls_pkg::POS_DRV_LSR2 +: stls_pkg::DRVLS_W]};
        cslew_nxt = first_i[stls_pkg::POS_CSLEW_R2 +: stls_pkg::SLEW_W];
        fslew_nxt = first_i[stls_pkg::POS_FSLEW_R2 +: stls_pkg::SLEW_W];
      end
      default: begin
        drv_nxt = '0;
      end
    endcase
    if (direct) begin
      drv_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_level_o     <= '0;
      deemph_coarse_o <= '0;
      deemph_fine_o   <= '0;
      tx_equal_o      <= '0;
      slew_coarse_o   <= '0;
      slew_fine_o     <= '0;
      margin_drive_o  <= 1'b0;
      margin_value_o  <= stls_pkg::MARGIN_RST;
    end else begin
      drv_level_o     <= drv_nxt;
      deemph_coarse_o <= cdc_nxt;
      deemph_fine_o   <= fdc_nxt;
      tx_equal_o      <= txeq_nxt;
      slew_coarse_o   <= cslew_nxt;
      slew_fine_o     <= fslew_nxt;
      margin_drive_o  <= direct;
      margin_value_o  <= margin_i;
    end
  end

endmodule : stls_lane_drv

//--- hdl/stls_top.sv
// Purpose: register bank and per-lane transmit driver selection for lane quads
// Assumes: port mode inputs come from the physical layer on clk_i
// Notes:   lane outputs follow any register or mode change one cycle later
//
// Functional notes
// - normal margin code: lane settings come from the quad lane register pair
// - other margin code drives all port lanes directly; lane drive level zeroed, other lane fields kept
// - every lane has its own register pair, addressed by quad number and target control
// - unmerged port n governs quad n
// - merged port uses even port margin for both quads; both pairs apply
// - separate field sets for five swing, rate, de-emphasis modes
// - full swing applies mode de-emphasis, equalization, drive and rate slew
// - low swing applies only its drive level and rate slew fields
// - slews, equalization, coarse de-emphasis in first; fine and drive second
// - reset defaults suit all five modes; software may overwrite them
// - mode change switches lanes to the new field set automatically
// - register writes reach the drivers one cycle later, no retrain needed
// - target control chooses one lane or all lanes for pair writes
// - low swing forces de-emphasis off, de-emphasis select ignored
// - merged port is an even port plus the next odd one, two quads
`timescale 1ns/100ps
module stls_top #(
  parameter int NUM_QUADS = 4,
  parameter int LANES     = 4
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic [stls_pkg::BUS_AW-1:0]            addr_i,
  input  wire logic [stls_pkg::BUS_DW-1:0]            wdata_i,
  input  wire logic                                   wr_i,
  input  wire logic                                   rd_i,
  output logic      [stls_pkg::BUS_DW-1:0]            rdata_o,
  input  wire logic [NUM_QUADS-1:0]                   rate_two_i,
  input  wire logic [NUM_QUADS-1:0]                   low_swing_i,
  input  wire logic [NUM_QUADS-1:0]                   deemph_sel_i,
  input  wire logic [NUM_QUADS/2-1:0]                 merge_i,
  output logic [NUM_QUADS*LANES*stls_pkg::DRV_W-1:0]  drv_level_o,
  output logic [NUM_QUADS*LANES*stls_pkg::CDC_W-1:0]  deemph_coarse_o,
  output logic [NUM_QUADS*LANES*stls_pkg::FDC_W-1:0]  deemph_fine_o,
  output logic [NUM_QUADS*LANES*stls_pkg::TXEQ_W-1:0] tx_equal_o,
  output logic [NUM_QUADS*LANES*stls_pkg::SLEW_W-1:0] slew_coarse_o,
  output logic [NUM_QUADS*LANES*stls_pkg::SLEW_W-1:0] slew_fine_o,
  output logic [NUM_QUADS*LANES-1:0]                  margin_drive_o,
  output logic [NUM_QUADS*LANES*stls_pkg::MARGIN_W-1:0] margin_value_o
);

  localparam int NL = NUM_QUADS * LANES;

  if (NUM_QUADS < 2 || NUM_QUADS > 32 || (NUM_QUADS % 2) != 0) begin : g_bad_quads
    $error("NUM_QUADS must be even and between 2 and 32");
  end
  if (LANES < 1 || LANES > 4) begin : g_bad_lanes
    $error("LANES must be between 1 and 4");
  end

  // register state
  logic [31:0]                   first_r  [NL];
  logic [31:0]                   second_r [NL];
  logic [stls_pkg::LSEL_W-1:0]   lane_sel_r  [NUM_QUADS];
  logic                          all_lanes_r [NUM_QUADS];
  logic [stls_pkg::MARGIN_W-1:0] margin_r    [NUM_QUADS];
  logic [stls_pkg::BUS_DW-1:0]   rdata_r;
  logic [stls_pkg::BUS_DW-1:0]   rdata_nxt;

  // per-port mode and per-quad governing selection
  stls_pkg::stls_mode_t          port_mode [NUM_QUADS];
  stls_pkg::stls_mode_t          quad_mode [NUM_QUADS];
  logic [stls_pkg::MARGIN_W-1:0] quad_margin [NUM_QUADS];
  logic [NUM_QUADS-1:0]          quad_merged;

  // address decode
  logic                          quad_hit;
  logic                          port_hit;
  logic [5:0]                    quad_idx;
  logic [6:0]                    port_idx;
  logic [3:0]                    word_ofs;

  assign quad_idx = addr_i[stls_pkg::BUS_AW-1:stls_pkg::QUAD_STRIDE_SH];
  assign word_ofs = addr_i[stls_pkg::QUAD_STRIDE_SH-1:0];
  assign port_idx = addr_i[8:2];
  assign quad_hit = (addr_i < stls_pkg::PORT_BASE) && (int'(quad_idx) < NUM_QUADS);
  assign port_hit = (addr_i >= stls_pkg::PORT_BASE) && (addr_i[1:0] == 2'h0)
                    && (int'(port_idx) < NUM_QUADS);

  function automatic stls_pkg::stls_mode_t mode_of(input logic rate_two,
                                                   input logic low_swing,
                                                   input logic sel_35);
    stls_pkg::stls_mode_t m;
    if (low_swing) begin
      m = rate_two ? stls_pkg::STLS_LS_R2 : stls_pkg::STLS_LS_R1;
    end else if (!rate_two) begin
      m = stls_pkg::STLS_FS35_R1;
    end else begin
      m = sel_35 ? stls_pkg::STLS_FS35_R2 : stls_pkg::STLS_FS60_R2;
    end
    return m;
  endfunction : mode_of

  genvar q;
  genvar l;
  generate
    for (q = 0; q < NUM_QUADS; q++) begin : g_quad
      localparam int GOV = (q % 2 == 0) ? q : q - 1;
      logic mrg;
      logic tgt_wr;
      logic mg_wr;

      assign mrg = merge_i[q/2];
      assign quad_merged[q] = mrg;
      assign port_mode[q]   = mode_of(rate_two_i[q], low_swing_i[q], deemph_sel_i[q]);
      // merged pairs follow the even port, otherwise the own port
      assign quad_mode[q]   = mrg ? port_mode[GOV] : port_mode[q];
      assign quad_margin[q] = mrg ? margin_r[GOV] : margin_r[q];
      assign tgt_wr = wr_i && quad_hit && (int'(quad_idx) == q)
                      && (word_ofs == stls_pkg::OFS_TARGET);
      assign mg_wr  = wr_i && port_hit && (int'(port_idx) == q);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lane_sel_r[q]  <= stls_pkg::LANE_SEL_RST;
          all_lanes_r[q] <= stls_pkg::ALL_LANES_RST;
        end else if (tgt_wr) begin
          lane_sel_r[q]  <= wdata_i[stls_pkg::POS_LANE_SEL +: stls_pkg::LSEL_W];
          all_lanes_r[q] <= wdata_i[stls_pkg::POS_ALL_LANES];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          margin_r[q] <= stls_pkg::MARGIN_RST;
        end else if (mg_wr) begin
          margin_r[q] <= wdata_i[stls_pkg::POS_MARGIN +: stls_pkg::MARGIN_W];
        end
      end

      for (l = 0; l < LANES; l++) begin : g_lane
        localparam int IDX = q * LANES + l;
        logic lane_hit;

        assign lane_hit = wr_i && quad_hit && (int'(quad_idx) == q)
                          && (all_lanes_r[q] || (int'(lane_sel_r[q]) == l));

        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            first_r[IDX] <= stls_pkg::TXL_FIRST_RST;
          end else if (lane_hit && word_ofs == stls_pkg::OFS_TXL_FIRST) begin
            first_r[IDX] <= wdata_i & stls_pkg::TXL_FIRST_MASK;
          end
        end

        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            second_r[IDX] <= stls_pkg::TXL_SECOND_RST;
          end else if (lane_hit && word_ofs == stls_pkg::OFS_TXL_SECOND) begin
            second_r[IDX] <= wdata_i & stls_pkg::TXL_SECOND_MASK;
          end
        end

        stls_lane_drv u_drv (
          .clk_i           (clk_i),
          .rst_i           (rst_i),
          .first_i         (first_r[IDX]),
          .second_i        (second_r[IDX]),
          .mode_i          (quad_mode[q]),
          .margin_i        (quad_margin[q]),
          .drv_level_o     (drv_level_o[IDX*stls_pkg::DRV_W +: stls_pkg::DRV_W]),
          .deemph_coarse_o (deemph_coarse_o[IDX*stls_pkg::CDC_W +: stls_pkg::CDC_W]),
          .deemph_fine_o   (deemph_fine_o[IDX*stls_pkg::FDC_W +: stls_pkg::FDC_W]),
          .tx_equal_o      (tx_equal_o[IDX*stls_pkg::TXEQ_W +: stls_pkg::TXEQ_W]),
          .slew_coarse_o   (slew_coarse_o[IDX*stls_pkg::SLEW_W +: stls_pkg::SLEW_W]),
          .slew_fine_o     (slew_fine_o[IDX*stls_pkg::SLEW_W +: stls_pkg::SLEW_W]),
          .margin_drive_o  (margin_drive_o[IDX]),
          .margin_value_o  (margin_value_o[IDX*stls_pkg::MARGIN_W +: stls_pkg::MARGIN_W])
        );
      end
    end
  endgenerate

  // read mux: pair reads show the lane chosen by the target control
  always_comb begin
    int qi;
    int li;
    int pi;
    qi        = 0;
    li        = 0;
    pi        = 0;
    rdata_nxt = '0;
    if (quad_hit) begin
      qi = int'(quad_idx);
      li = int'(lane_sel_r[qi]);
      if (li >= LANES) begin
        li = LANES - 1;
      end
      unique case (word_ofs)
        stls_pkg::OFS_TXL_FIRST:  rdata_nxt = first_r[qi*LANES + li];
        stls_pkg::OFS_TXL_SECOND: rdata_nxt = second_r[qi*LANES + li];
        stls_pkg::OFS_TARGET: begin
          rdata_nxt[stls_pkg::POS_LANE_SEL +: stls_pkg::LSEL_W] = lane_sel_r[qi];
          rdata_nxt[stls_pkg::POS_ALL_LANES]                    = all_lanes_r[qi];
        end
        default: rdata_nxt = '0;
      endcase
    end else if (port_hit) begin
      pi = int'(port_idx);
      rdata_nxt[stls_pkg::POS_MARGIN +: stls_pkg::MARGIN_W] = margin_r[pi];
      rdata_nxt[stls_pkg::POS_MODE_STAT +: 3]       = quad_mode[pi];
      rdata_nxt[stls_pkg::POS_MERGED]               = quad_merged[pi];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_o = rdata_r;

endmodule : stls_top

//--- verification/stls_top_monitor.sv
// Purpose: port-level checks of lane driver selection
// Assumes: quads 0 and 1 form the first mergeable pair
// Notes:   watches lane 0, the last lane of quad 0 and lane 0 of quad 1
`timescale 1ns/100ps
module stls_top_monitor #(
  parameter int NUM_QUADS = 4,
  parameter int LANES     = 4
) (
  input wire logic                                   clk_i,
  input wire logic                                   rst_i,
  input wire logic [NUM_QUADS-1:0]                   low_swing_i,
  input wire logic [NUM_QUADS/2-1:0]                 merge_i,
  input wire logic [NUM_QUADS*LANES*stls_pkg::DRV_W-1:0]  drv_level_o,
  input wire logic [NUM_QUADS*LANES*stls_pkg::CDC_W-1:0]  deemph_coarse_o,
  input wire logic [NUM_QUADS*LANES*stls_pkg::FDC_W-1:0]  deemph_fine_o,
  input wire logic [NUM_QUADS*LANES*stls_pkg::TXEQ_W-1:0] tx_equal_o,
  input wire logic [NUM_QUADS*LANES-1:0]                  margin_drive_o,
  input wire logic [NUM_QUADS*LANES*stls_pkg::MARGIN_W-1:0] margin_value_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ls_held;
    low_swing_i[0] ##1 low_swing_i[0];
  endsequence
  sequence s_mrg_ls_held;
    (merge_i[0] && low_swing_i[0]) ##1 (merge_i[0] && low_swing_i[0]);
  endsequence
  a_ls_no_deemph: assert property (s_ls_held |->
    (deemph_coarse_o[2:0] | deemph_fine_o[2:0]) == 3'h0)
    else $error("de-emphasis active in low swing");
  a_ls_drive_only: assert property (s_ls_held |-> tx_equal_o[1:0] == 2'h0 && !drv_level_o[4])
    else $error("low swing uses full swing fields");
  a_margin_drive_zero: assert property (margin_drive_o[0] |-> drv_level_o[4:0] == 5'h00)
    else $error("lane drive level kept under margin drive");
  a_margin_code_nz: assert property (margin_drive_o[0] |-> margin_value_o[2:0] != 3'h0)
    else $error("margin drive with normal code");
  a_normal_code: assert property (!margin_drive_o[0] |-> margin_value_o[2:0] == 3'h0)
    else $error("margin value shown at normal range");
  a_port_lanes_same: assert property (margin_drive_o[LANES-1] == margin_drive_o[0]
    && margin_value_o[(LANES-1)*3 +: 3] == margin_value_o[2:0])
    else $error("port lanes differ in margin");
  a_merged_margin: assert property (merge_i[0] && $past(merge_i[0]) |->
    margin_value_o[LANES*3 +: 3] == margin_value_o[2:0])
    else $error("odd quad margin differs when merged");
  a_merged_ls: assert property (s_mrg_ls_held |-> deemph_coarse_o[LANES*3 +: 3] == 3'h0)
    else $error("odd quad not following even port swing");
endmodule : stls_top_monitor

bind stls_top stls_top_monitor #(.NUM_QUADS(NUM_QUADS), .LANES(LANES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .low_swing_i(low_swing_i), .merge_i(merge_i),
  .drv_level_o(drv_level_o), .deemph_coarse_o(deemph_coarse_o),
  .deemph_fine_o(deemph_fine_o), .tx_equal_o(tx_equal_o),
  .margin_drive_o(margin_drive_o), .margin_value_o(margin_value_o));

//--- verification/stls_phy_model.sv
// Purpose: physical layer model driving per-port swing, rate, de-emphasis
// Assumes: mode codes follow the package mode order
// Notes:   de-emphasis select toggles where the device must ignore it
`timescale 1ns/100ps
module stls_phy_model #(
  parameter int NUM_QUADS = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [NUM_QUADS*3-1:0] mode_i,
  output logic      [NUM_QUADS-1:0]   rate_two_o,
  output logic      [NUM_QUADS-1:0]   low_swing_o,
  output logic      [NUM_QUADS-1:0]   deemph_sel_o
);
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_QUADS; p++) begin
      if (rst_i) begin
        {rate_two_o[p], low_swing_o[p], deemph_sel_o[p]} <= 3'h0;
      end else begin
        rate_two_o[p]   <= mode_i[p*3 +: 3] inside {3'h1, 3'h2, 3'h4};
        low_swing_o[p]  <= mode_i[p*3 +: 3] >= 3'h3;
        deemph_sel_o[p] <= (mode_i[p*3 +: 3] == 3'h1) |
                           ((mode_i[p*3 +: 3] != 3'h2) & ~deemph_sel_o[p]);
      end
    end
  end
endmodule : stls_phy_model

//--- verification/stls_top_bench.sv
// Purpose: register and lane selection tests of the transmit level selector
// Assumes: four quads of four lanes, ports ordered {p3,p2,p1,p0} in mode_c
// Notes:   lane expectations are rebuilt from the written register images
`timescale 1ns/100ps
module stls_top_bench;
  logic        clk_i, rst_i, wr_i, rd_i;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [1:0]  merge_i;
  logic [11:0] mode_c;
  logic [3:0]  rate_two, low_swing, deemph_sel;
  logic [79:0] drv;
  logic [47:0] cdc, fdc, sc, sf, mv;
  logic [31:0] eq;
  logic [15:0] md;
  logic [31:0] f_e[16], s_e[16];
  logic [2:0]  mg_e[4];
  int          n_mismatch, n_checks;

  stls_top #(.NUM_QUADS(4), .LANES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rate_two_i(rate_two),
    .low_swing_i(low_swing), .deemph_sel_i(deemph_sel), .merge_i(merge_i),
    .drv_level_o(drv), .deemph_coarse_o(cdc), .deemph_fine_o(fdc), .tx_equal_o(eq),
    .slew_coarse_o(sc), .slew_fine_o(sf), .margin_drive_o(md), .margin_value_o(mv));
  stls_phy_model #(.NUM_QUADS(4)) u_phy (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_c),
    .rate_two_o(rate_two), .low_swing_o(low_swing), .deemph_sel_o(deemph_sel));

  function automatic logic [22:0] exp_lane(input logic [31:0] f, s, input logic [2:0] m, mg);
    logic [4:0] dv;
    logic [2:0] cd, fd, c, n;
    logic [1:0] q;
    {dv, cd, fd, q} = '0;
    c = (m == 3'h0 || m == 3'h3) ? f[2:0] : f[5:3];
    n = (m == 3'h0 || m == 3'h3) ? f[14:12] : f[17:15];
    case (m)
      3'h0: {dv, cd, fd, q} = {s[13:9], f[20:18], s[2:0], f[7:6]};
      3'h1: {dv, cd, fd, q} = {s[18:14], f[23:21], s[5:3], f[9:8]};
      3'h2: {dv, cd, fd, q} = {s[23:19], f[26:24], s[8:6], f[11:10]};
      3'h3: dv = {1'b0, s[27:24]};
      default: dv = {1'b0, s[31:28]};
    endcase
    if (mg != 3'h0) dv = '0;
    return {dv, cd, fd, q, c, n, mg != 3'h0, mg};
  endfunction : exp_lane

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk_reg(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_lanes();
    int p;
    logic [22:0] g, e;
    for (int i = 0; i < 16; i++) begin
      p = (merge_i[i/8] && (i/4) % 2 == 1) ? i/4 - 1 : i/4;
      e = exp_lane(f_e[i], s_e[i], mode_c[p*3 +: 3], mg_e[p]);
      g = {drv[i*5 +: 5], cdc[i*3 +: 3], fdc[i*3 +: 3], eq[i*2 +: 2], sc[i*3 +: 3],
           sf[i*3 +: 3], md[i], mv[i*3 +: 3]};
      n_checks++;
      if (g !== e) begin
        n_mismatch++;
        $display("mismatch at %0t: lane %0d got %h expected %h", $time, i, g, e);
      end
    end
  endtask : chk_lanes

  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic pair(input int q, input logic [1:0] ln, input logic all,
                      input logic [31:0] f, s);
    wr(10'(q*16 + 8), 32'({all, 2'b00, ln}));
    wr(10'(q*16), f);
    wr(10'(q*16 + 4), s);
    for (int l = 0; l < 4; l++) if (all || l == ln) begin
      f_e[q*4+l] = f & 32'h07ff_ffff;
      s_e[q*4+l] = s;
    end
  endtask : pair

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end

  initial begin
    {wr_i, rd_i, merge_i, mode_c, addr_i, wdata_i} = '0;
    rst_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      f_e[i] = stls_pkg::TXL_FIRST_RST;
      s_e[i] = stls_pkg::TXL_SECOND_RST;
    end
    for (int p = 0; p < 4; p++) mg_e[p] = 3'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(10'h000, d); chk_reg(d, stls_pkg::TXL_FIRST_RST);
    rd(10'h034, d); chk_reg(d, stls_pkg::TXL_SECOND_RST);
    rd(10'h028, d); chk_reg(d, 32'h0);
    rd(10'h204, d); chk_reg(d, 32'h0);
    chk_lanes();
    pair(1, 2'h2, 1'b0, 32'h0555_5555, 32'hdead_beef);
    @(posedge clk_i);
    #1 chk_lanes();
    rd(10'h010, d); chk_reg(d, 32'h0555_5555);
    pair(2, 2'h1, 1'b1, 32'h02aa_aaaa, 32'h1234_5678);
    settle(); chk_lanes();
    pair(0, 2'h3, 1'b0, 32'hffff_ffff, 32'h0);
    rd(10'h000, d); chk_reg(d, 32'h07ff_ffff);
    rd(10'h00c, d); chk_reg(d, 32'h0);
    rd(10'h3fc, d); chk_reg(d, 32'h0);
    wr(10'h3fc, 32'hffff_ffff);
    wr(10'h201, 32'h0000_0005);
    wr(10'h20c, 32'h0000_0007);
    mg_e[3] = 3'h7;
    settle(); chk_lanes();
    for (int m = 0; m < 5; m++) begin
      @(posedge clk_i);
      mode_c <= {4{3'(m)}};
      settle(); chk_lanes();
      rd(10'h200, d); chk_reg(d, 32'(m) << 4);
    end
    @(posedge clk_i);
    mode_c <= {3'h4, 3'h4, 3'h0, 3'h4};
    wr(10'h200, 32'h0000_0003);
    mg_e[0] = 3'h3;
    settle(); chk_lanes();
    wr(10'h204, 32'h0000_0006);
    mg_e[1] = 3'h6;
    @(posedge clk_i);
    merge_i <= 2'b01;
    settle(); chk_lanes();
    rd(10'h204, d); chk_reg(d, 32'h0000_0146);
    wr(10'h200, 32'h0);
    mg_e[0] = 3'h0;
    settle(); chk_lanes();
    @(posedge clk_i);
    merge_i <= 2'b00;
    settle(); chk_lanes();
    final_report();
  end
endmodule : stls_top_bench
